// File: hw/extended_opcode_decoder.sv
`default_nettype none
module extended_opcode_decoder
   import xop_pkg::*;
(
   input  wire logic             i_clk_sys,
   input  wire logic             i_sys_rst,
   input  wire logic             i_valid,
   input  wire logic [OPC_W-1:0] i_opcode,
   input  wire logic             i_exec_done,
   output logic                  o_ready,
   output logic                  o_issue,
   output xop_t                  o_op,
   output logic [CYC_W-1:0]      o_cyc_min,
   output logic [CYC_W-1:0]      o_cyc_max,
   output logic                  o_variable
);
   xop_if lut ();
   logic  busy;
   logic  take;

   assign lut.opcode = i_opcode;
   xop_table u_table (.bus(lut));

   ////////////////////////////////////////////////////////////////
   // an opcode is taken only when the previous one has finished
   assign take = i_valid && o_ready;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_issue    <= 1'b0;
         o_op       <= OP_ILLEGAL;
         o_cyc_min  <= '0;
         o_cyc_max  <= '0;
         o_variable <= 1'b0;
      end else begin
         o_issue <= take;
         if (take) begin
            o_op       <= lut.dec.op;
            o_cyc_min  <= lut.dec.cyc_min;
            o_cyc_max  <= lut.dec.cyc_max;
            o_variable <= lut.dec.variable;
         end
      end
   end

   xop_busy u_busy (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_start   (take),
      .i_cycles  (lut.dec.cyc_min),
      .i_variable(lut.dec.variable),
      .i_done    (i_exec_done),
      .o_busy    (busy)
   );

   // ready registered so the output is a flop; lags busy by design
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) o_ready <= 1'b1;
      else o_ready <= !busy && !take;
   end

   ////////////////////////////////////////////////////////////////
   chk_range_cycles: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h2cf7 |=> o_op == OP_CIR && o_cyc_min == 5'h03)
      else $error("range check decode wrong");
   chk_sext_cycles: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h2ff8 |=> o_cyc_max == 5'h03 && !o_variable)
      else $error("sign extend decode wrong");
   chk_half_store: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h2cf8 |=> o_cyc_min == 5'h02)
      else $error("half store cycles wrong");
   chk_sext_load: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h2bf9 |=> o_op == OP_LBX ##1 o_ready)
      else $error("sign load not single cycle");
   chk_dev_move: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h62f4 |=> o_variable && o_cyc_max == CYC_UNSPEC)
      else $error("device move not variable");
   chk_sem_wait: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h60f5 |=> o_cyc_min == 5'h05 && o_cyc_max == 5'h0b)
      else $error("wait bounds wrong");
   sequence s_trap_taken;
      take && i_opcode == 16'h26fe;
   endsequence
   chk_trap_busy: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_trap_taken |=> !o_ready [*8])
      else $error("trap access not held");
   chk_hold_done: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && lut.dec.variable ##1 !i_exec_done |=> !o_ready)
      else $error("issued before completion");

   ////////////////////////////////////////////////////////////////
   // fixed-count groups and the ranged trap return not guarded above: a wrong table row shows up here first
   chk_swap_timer: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h60f1 |=> o_cyc_min == 5'h05 && !o_variable)
      else $error("timer queue swap cycles wrong");
   chk_glob_int: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h2cfd |=> o_op == OP_GINTDIS && o_cyc_min == 5'h05)
      else $error("global interrupt disable wrong");
   chk_restart_len: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h62fe |=> o_cyc_min == 5'h14 && !o_variable)
      else $error("restart cycles wrong");
   chk_trap_ret: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h60fb |=> o_variable && o_cyc_min == 5'h08 && o_cyc_max == 5'h0a)
      else $error("trap return bounds wrong");
   // single-cycle ops must free the issue slot again right after the pulse
   sequence s_prodid_taken;
      take && i_opcode == 16'h68fc;
   endsequence
   chk_prod_id: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      s_prodid_taken |=> o_op == OP_PRODID ##1 o_ready)
      else $error("product identity not single cycle");
   chk_clk_ctrl: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      take && i_opcode == 16'h64fc |=> o_op == OP_STCLK && o_cyc_min == 5'h02)
      else $error("clock store decode wrong");
endmodule : extended_opcode_decoder
`default_nettype wire

// File: hw/xop_busy.sv
`default_nettype none
module xop_busy
   import xop_pkg::*;
(
   input  wire logic             i_clk_sys,
   input  wire logic             i_sys_rst,
   input  wire logic             i_start,
   input  wire logic [CYC_W-1:0] i_cycles,
   input  wire logic             i_variable,
   input  wire logic             i_done,
   output logic                  o_busy
);
   logic [CYC_W-1:0] left;
   logic             wait_done;

   // fixed counts count down; ranged ones wait for completion, then count down the rest of cyc_min
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         left      <= '0;
         wait_done <= 1'b0;
      end else if (i_start) begin
         left      <= i_cycles - 5'h01;
         wait_done <= i_variable;
      end else if (wait_done) begin
         if (i_done) wait_done <= 1'b0;
      end else if (left != '0) begin
         left <= left - 5'h01;
      end
   end
   assign o_busy = wait_done || (left != '0);
endmodule : xop_busy
`default_nettype wire

// File: hw/xop_if.sv
`default_nettype none
interface xop_if;
   import xop_pkg::*;
   logic [OPC_W-1:0] opcode;
   xdec_t            dec;
   modport table_side (input opcode, output dec);
   modport user_side  (output opcode, input dec);
endinterface : xop_if
`default_nettype wire

// File: hw/xop_pkg.sv
`default_nettype none
package xop_pkg;
   localparam int OPC_W = 16;
   localparam int CYC_W = 5;
   typedef enum logic [5:0] {
      OP_ILLEGAL = 6'h00, OP_CIR = 6'h01, OP_CIRU = 6'h02, OP_CHK_BYTE = 6'h03,
      OP_CHK_BYTE_U = 6'h04, OP_CHK_SIXTEEN = 6'h05, OP_CHK_SIXTEEN_U = 6'h06,
      OP_XSWORD = 6'h07, OP_XBWORD = 6'h08, OP_SSUB = 6'h09, OP_LOAD_HALF = 6'h0a,
      OP_STORE_HALF = 6'h0b, OP_LBX = 6'h0c, OP_LSX = 6'h0d, OP_DEVLB = 6'h0e,
      OP_DEVSB = 6'h0f, OP_DEVLS = 6'h10, OP_DEVSS = 6'h11, OP_DEVLW = 6'h12,
      OP_DEVSW = 6'h13, OP_DEVMOVE = 6'h14, OP_SEM_WAIT = 6'h15, OP_SEM_SIGNAL = 6'h16,
      OP_SWAPQ = 6'h17, OP_SWAPTMR = 6'h18, OP_INSERTQ = 6'h19, OP_TIMESLICE = 6'h1a,
      OP_LDSHADOW = 6'h1b, OP_STSHADOW = 6'h1c, OP_RESTART = 6'h1d,
      OP_CAUSEERR = 6'h1e, OP_IRET = 6'h1f, OP_SETTSLICE = 6'h20, OP_INTDIS = 6'h21,
      OP_INTENB = 6'h22, OP_GINTDIS = 6'h23, OP_GINTENB = 6'h24, OP_LDTRAPH = 6'h25,
      OP_LDTRAPPED = 6'h26, OP_STTRAPPED = 6'h27, OP_STTRAPH = 6'h28,
      OP_TRAPENB = 6'h29, OP_TRAPDIS = 6'h2a, OP_TRET = 6'h2b, OP_PRODID = 6'h2c,
      OP_NOP = 6'h2d, OP_CLKENB = 6'h2e, OP_CLKDIS = 6'h2f, OP_LDCLK = 6'h30,
      OP_STCLK = 6'h31
   } xop_t;
   typedef struct packed {
      xop_t             op;
      logic [CYC_W-1:0] cyc_min;
      logic [CYC_W-1:0] cyc_max;   // 0 means unspecified
      logic             variable;
   } xdec_t;
   localparam logic [CYC_W-1:0] CYC_UNSPEC = 5'h00;
endpackage : xop_pkg
`default_nettype wire

// File: hw/xop_table.sv
`default_nettype none
module xop_table
   import xop_pkg::*;
(
   xop_if.table_side bus
);
   // pure lookup: opcode to operation and cycle bounds
   function automatic xdec_t mk(input xop_t o, input int lo, input int hi);
      xdec_t d;
      d.op       = o;
      d.cyc_min  = lo[CYC_W-1:0];
      d.cyc_max  = hi[CYC_W-1:0];
      d.variable = (lo != hi);
      return d;
   endfunction : mk

   always_comb begin
      case (bus.opcode)
         16'h2cf7: bus.dec = mk(OP_CIR, 3, 3);
         16'h2cfc: bus.dec = mk(OP_CIRU, 3, 3);
         16'h2bfa: bus.dec = mk(OP_CHK_BYTE, 3, 3);
         16'h2bfb: bus.dec = mk(OP_CHK_BYTE_U, 2, 2);
         16'h2ffa: bus.dec = mk(OP_CHK_SIXTEEN, 3, 3);
         16'h2ffb: bus.dec = mk(OP_CHK_SIXTEEN_U, 2, 2);
         16'h2ff8: bus.dec = mk(OP_XSWORD, 3, 3);
         16'h2bf8: bus.dec = mk(OP_XBWORD, 3, 3);
         16'h2cf1: bus.dec = mk(OP_SSUB, 1, 1);
         16'h2cfa: bus.dec = mk(OP_LOAD_HALF, 1, 1);
         16'h2cf8: bus.dec = mk(OP_STORE_HALF, 2, 2);
         16'h2bf9: bus.dec = mk(OP_LBX, 1, 1);
         16'h2ff9: bus.dec = mk(OP_LSX, 1, 1);
         16'h2ff0: bus.dec = mk(OP_DEVLB, 3, 3);
         16'h2ff1: bus.dec = mk(OP_DEVSB, 3, 3);
         16'h2ff2: bus.dec = mk(OP_DEVLS, 3, 3);
         16'h2ff3: bus.dec = mk(OP_DEVSS, 3, 3);
         16'h2ff4: bus.dec = mk(OP_DEVLW, 3, 3);
         16'h2ff5: bus.dec = mk(OP_DEVSW, 3, 3);
         16'h62f4: bus.dec = mk(OP_DEVMOVE, 1, 0);
         16'h60f5: bus.dec = mk(OP_SEM_WAIT, 5, 11);
         16'h60f4: bus.dec = mk(OP_SEM_SIGNAL, 7, 12);
         16'h60f0: bus.dec = mk(OP_SWAPQ, 4, 4);
         16'h60f1: bus.dec = mk(OP_SWAPTMR, 5, 5);
         16'h60f2: bus.dec = mk(OP_INSERTQ, 3, 4);
         16'h60f3: bus.dec = mk(OP_TIMESLICE, 3, 4);
         16'h60fc: bus.dec = mk(OP_LDSHADOW, 6, 31);
         16'h60fd: bus.dec = mk(OP_STSHADOW, 6, 17);
         16'h62fe: bus.dec = mk(OP_RESTART, 20, 20);
         16'h62ff: bus.dec = mk(OP_CAUSEERR, 7, 8);
         16'h61ff: bus.dec = mk(OP_IRET, 3, 11);
         16'h2bf0: bus.dec = mk(OP_SETTSLICE, 2, 2);
         16'h2cf4: bus.dec = mk(OP_INTDIS, 2, 2);
         16'h2cf5: bus.dec = mk(OP_INTENB, 2, 2);
         16'h2cfd: bus.dec = mk(OP_GINTDIS, 5, 5);
         16'h2cfe: bus.dec = mk(OP_GINTENB, 5, 5);
         16'h26fe: bus.dec = mk(OP_LDTRAPH, 12, 12);
         16'h2cf6: bus.dec = mk(OP_LDTRAPPED, 12, 12);
         16'h2cfb: bus.dec = mk(OP_STTRAPPED, 12, 12);
         16'h26ff: bus.dec = mk(OP_STTRAPH, 12, 12);
         16'h60f7: bus.dec = mk(OP_TRAPENB, 4, 4);
         16'h60f6: bus.dec = mk(OP_TRAPDIS, 4, 4);
         16'h60fb: bus.dec = mk(OP_TRET, 8, 10);
         16'h68fc: bus.dec = mk(OP_PRODID, 1, 1);
         16'h63f0: bus.dec = mk(OP_NOP, 1, 1);
         16'h64ff: bus.dec = mk(OP_CLKENB, 2, 2);
         16'h64fe: bus.dec = mk(OP_CLKDIS, 2, 2);
         16'h64fd: bus.dec = mk(OP_LDCLK, 2, 2);
         16'h64fc: bus.dec = mk(OP_STCLK, 2, 2);
         default:  bus.dec = mk(OP_ILLEGAL, 1, 1);
      endcase
   end
endmodule : xop_table
`default_nettype wire

// File: testbench/extended_opcode_decoder_tb.sv
`default_nettype none
module extended_opcode_decoder_tb;
   import xop_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [OPC_W-1:0] code;
      xop_t             op;
      logic [CYC_W-1:0] lo;
      logic [CYC_W-1:0] hi;
   } row_t;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             valid = 1'b0;
   logic [OPC_W-1:0] opcode = 16'h0000;
   logic [3:0]       delay = 4'h0;
   logic             done, ready, issue, vf;
   xop_t             op;
   logic [CYC_W-1:0] cmin, cmax;
   int               fails = 0;
   int               check_count = 0;
   // corner set: every group, with ranged and open-ended counts among them
   row_t             rows [49] = '{
      '{16'h2cf7, OP_CIR, 5'h03, 5'h03}, '{16'h2bfb, OP_CHK_BYTE_U, 5'h02, 5'h02},
      '{16'h2ff8, OP_XSWORD, 5'h03, 5'h03}, '{16'h2bf8, OP_XBWORD, 5'h03, 5'h03},
      '{16'h2cf1, OP_SSUB, 5'h01, 5'h01}, '{16'h2cfa, OP_LOAD_HALF, 5'h01, 5'h01},
      '{16'h2cf8, OP_STORE_HALF, 5'h02, 5'h02}, '{16'h2bf9, OP_LBX, 5'h01, 5'h01},
      '{16'h2ff0, OP_DEVLB, 5'h03, 5'h03}, '{16'h2ff5, OP_DEVSW, 5'h03, 5'h03},
      '{16'h62f4, OP_DEVMOVE, 5'h01, 5'h00}, '{16'h60f5, OP_SEM_WAIT, 5'h05, 5'h0b},
      '{16'h60f4, OP_SEM_SIGNAL, 5'h07, 5'h0c}, '{16'h60f0, OP_SWAPQ, 5'h04, 5'h04},
      '{16'h60f2, OP_INSERTQ, 5'h03, 5'h04}, '{16'h2cf4, OP_INTDIS, 5'h02, 5'h02},
      '{16'h2cfd, OP_GINTDIS, 5'h05, 5'h05}, '{16'h61ff, OP_IRET, 5'h03, 5'h0b},
      '{16'h60fc, OP_LDSHADOW, 5'h06, 5'h1f}, '{16'h62fe, OP_RESTART, 5'h14, 5'h14},
      '{16'h26fe, OP_LDTRAPH, 5'h0c, 5'h0c}, '{16'h60fb, OP_TRET, 5'h08, 5'h0a},
      '{16'h60f7, OP_TRAPENB, 5'h04, 5'h04}, '{16'h68fc, OP_PRODID, 5'h01, 5'h01},
      '{16'h64ff, OP_CLKENB, 5'h02, 5'h02}, '{16'h2cfc, OP_CIRU, 5'h03, 5'h03},
      '{16'h2bfa, OP_CHK_BYTE, 5'h03, 5'h03}, '{16'h2ffa, OP_CHK_SIXTEEN, 5'h03, 5'h03},
      '{16'h2ffb, OP_CHK_SIXTEEN_U, 5'h02, 5'h02}, '{16'h2ff9, OP_LSX, 5'h01, 5'h01},
      '{16'h2ff1, OP_DEVSB, 5'h03, 5'h03}, '{16'h2ff2, OP_DEVLS, 5'h03, 5'h03},
      '{16'h2ff3, OP_DEVSS, 5'h03, 5'h03}, '{16'h2ff4, OP_DEVLW, 5'h03, 5'h03},
      '{16'h60f1, OP_SWAPTMR, 5'h05, 5'h05}, '{16'h60f3, OP_TIMESLICE, 5'h03, 5'h04},
      '{16'h60fd, OP_STSHADOW, 5'h06, 5'h11}, '{16'h62ff, OP_CAUSEERR, 5'h07, 5'h08},
      '{16'h2bf0, OP_SETTSLICE, 5'h02, 5'h02}, '{16'h2cf5, OP_INTENB, 5'h02, 5'h02},
      '{16'h2cfe, OP_GINTENB, 5'h05, 5'h05}, '{16'h2cf6, OP_LDTRAPPED, 5'h0c, 5'h0c},
      '{16'h2cfb, OP_STTRAPPED, 5'h0c, 5'h0c}, '{16'h26ff, OP_STTRAPH, 5'h0c, 5'h0c},
      '{16'h60f6, OP_TRAPDIS, 5'h04, 5'h04}, '{16'h64fe, OP_CLKDIS, 5'h02, 5'h02},
      '{16'h64fd, OP_LDCLK, 5'h02, 5'h02}, '{16'h64fc, OP_STCLK, 5'h02, 5'h02},
      '{16'h63f0, OP_NOP, 5'h01, 5'h01}};
   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   task automatic check_bit(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s is %b", $time, what, got);
      end
   endtask : check_bit
   // unknown codes decode as 1-cycle while their rows hold zeros, so only the op is compared for them
   task automatic check_dec(input row_t r);
      check_count++;
      if (op !== r.op ||
          (r.op != OP_ILLEGAL && {cmin, cmax, vf} !== {r.lo, r.hi, r.lo != r.hi})) begin
         fails++;
         $display("unexpected at %0t: code %h gave op %h", $time, r.code, op);
      end
   endtask : check_dec
   // one take, then a second request held into the busy cycle that must be ignored
   task automatic run_op(input row_t r);
      int   n;
      logic seen;
      n = 0;
      seen = 1'b0;
      @(posedge clk);
      delay <= 4'($urandom_range(15));
      valid <= 1'b1;
      opcode <= r.code;
      @(posedge clk);
      opcode <= 16'h63f0;
      #1;
      check_bit(issue, 1'b1, "issue pulse");
      check_dec(r);
      check_bit(ready, 1'b0, "ready after take");
      @(posedge clk);
      valid <= 1'b0;
      #1;
      check_bit(issue, 1'b0, "issue while busy");
      while (ready !== 1'b1 && n < 64) begin
         seen = seen | (done === 1'b1);
         n++;
         @(posedge clk);
         #1;
      end
      check_bit(ready, 1'b1, "ready return");
      if (r.lo != r.hi) check_bit(seen, 1'b1, "done before ready");
      else check_bit(n + 1 >= r.lo && n + 1 <= r.lo + 2, 1'b1, "busy span");
   endtask : run_op
   ////////////////////////////////////////////////////////////////////////////////////////////
   initial forever #2 clk = ~clk;
   // corner set first, then random legal and unknown codes
   initial begin
      void'($urandom(32'h9f44f4bc));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      #1;
      check_bit(ready & ~issue & (op === OP_ILLEGAL), 1'b1, "reset state");
      foreach (rows[i]) run_op(rows[i]);
      repeat (60) begin
         if ($urandom_range(1) == 1) run_op(rows[$urandom_range(48)]);
         else run_op(row_t'{16'($urandom_range(16'h1fff)), OP_ILLEGAL, 5'h00, 5'h00});
      end
      test_done();
   end
   // about thirty times the expected run length
   initial begin
      #100000;
      fails++;
      test_done();
   end
   extended_opcode_decoder dut (
      .i_clk_sys   (clk),
      .i_sys_rst   (rst),
      .i_valid     (valid),
      .i_opcode    (opcode),
      .i_exec_done (done),
      .o_ready     (ready),
      .o_issue     (issue),
      .o_op        (op),
      .o_cyc_min   (cmin),
      .o_cyc_max   (cmax),
      .o_variable  (vf)
   );
   xop_exec_model exec (
      .i_clk_sys  (clk),
      .i_sys_rst  (rst),
      .i_issue    (issue),
      .i_variable (vf),
      .i_delay    (delay),
      .o_done     (done)
   );
endmodule : extended_opcode_decoder_tb
`default_nettype wire

// File: testbench/xop_exec_model.sv
`default_nettype none
module xop_exec_model (
   input  wire logic       i_clk_sys,
   input  wire logic       i_sys_rst,
   input  wire logic       i_issue,
   input  wire logic       i_variable,
   input  wire logic [3:0] i_delay,
   output logic            o_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt;
   // ranged ops end after a bench-chosen delay, so prompt and slow ends both occur
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         cnt    <= 5'h00;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_issue && i_variable) begin
            cnt <= {1'b0, i_delay} + 5'h01;
         end else if (cnt != 5'h00) begin
            cnt    <= cnt - 5'h01;
            o_done <= (cnt == 5'h01);
         end
      end
   end
endmodule : xop_exec_model
`default_nettype wire
